/* File: hdl/stl_input_sampler.sv */
// periodic sampler for the low-active limit inputs
// assumes inputs synchronous to clk and a released reset
`default_nettype none
`include "stl_regs.svh"
module stl_input_sampler #(
  parameter int unsigned PERIOD = `STL_SAMPLE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] raw_n,
  output logic [1:0] held_n
);
  import stl_pkg::*;

  logic [31:0] cnt_q;

  // ****************************************
  // sample tick
  // ****************************************
  // sampling halves the 2 ms budget so worst case stays inside it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 32'h0;
    end else if (cnt_q >= PERIOD - 1) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  // idle high means no limit asserted after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      held_n <= 2'h3;
    end else if (cnt_q >= PERIOD - 1) begin
      held_n <= raw_n;
    end
  end
endmodule : stl_input_sampler
`default_nettype wire

/* File: hdl/stl_pkg.sv */
// types shared by the torque limit selector
// assumes stl_regs.svh sits beside it
`default_nettype none
package stl_pkg;
  typedef logic [8:0] stl_pct_type;
  typedef struct packed {
    logic we;
    logic re;
    logic [3:0] addr;
    logic [15:0] wdata;
  } stl_bus_req_type;
endpackage : stl_pkg
`default_nettype wire

/* File: hdl/stl_regs.svh */
// register offsets, field codes, reset values and timing counts for the torque limit selector
// assumes a 100 MHz clock and a plain strobe register port
//
// Overview of operation
// - internal positive and negative limits, 0..300 percent, reset 300
// - internal limits always apply, in percent of rated torque
// - any effective limit is clamped to the motor maximum torque
// - external positive and negative limits, 0..300 percent, reset 100
// - positive input low: smaller of internal and external positive limit
// - negative input low: smaller of internal and external negative limit
// - limit inputs take effect within 2 ms
// - analog limit applies only in speed or position control; code applies it in every mode but torque, mode code 3 included
// - analog limit uses magnitude and applies to both directions
// - analog terminal is a limit input only when the option selects it
// - analog terminal is feed-forward or limit, never both
// - analog torque reference is scaled by the reference gain
`ifndef STL_REGS_SVH
`define STL_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define STL_OFS_INT_POS 4'h0
`define STL_OFS_INT_NEG 4'h1
`define STL_OFS_EXT_POS 4'h2
`define STL_OFS_EXT_NEG 4'h3
`define STL_OFS_SPD_OPT 4'h4
`define STL_OFS_GAIN 4'h5
`define STL_OFS_MODE 4'h6
`define STL_OFS_MOTOR_MAX 4'h7
`define STL_OFS_STATUS 4'h8
`define STL_OFS_EFF_POS 4'h9
`define STL_OFS_EFF_NEG 4'hA
`define STL_OFS_AUX_IN 4'hB

// ****************************************
// reset values and ranges
// ****************************************
`define STL_LIMIT_MAX 9'h12C
`define STL_INT_RESET 9'h12C
`define STL_EXT_RESET 9'h064
`define STL_MOTOR_MAX_RESET 9'h12C
`define STL_GAIN_RESET 8'h0A
`define STL_SPD_OPT_RESET 2'h0
`define STL_MODE_RESET 2'h0

// speed control option field codes
`define STL_OPT_NONE 2'h0
`define STL_OPT_ALIMIT 2'h1
`define STL_OPT_FFWD 2'h2
`define STL_OPT_EXT_ALIMIT 2'h3

// control mode codes
`define STL_MODE_SPEED 2'h0
`define STL_MODE_POS 2'h1
`define STL_MODE_TORQUE 2'h2

// ****************************************
// timing
// ****************************************
`define STL_CLK_NS 10
`define STL_INPUT_LAT_NS 2000000
`define STL_SAMPLE_CYC (`STL_INPUT_LAT_NS / `STL_CLK_NS / 2)

`endif

/* File: hdl/stl_torque_limit.sv */
// servo torque limit selector: settings, limit selection and torque clamp
// assumes synchronous inputs, 100 MHz clk, signed analog and command samples
//
// The placing of the registers and the strobed register port are this design's own decisions.
`default_nettype none
`include "stl_regs.svh"
module stl_torque_limit #(
  parameter int unsigned SAMPLE_CYC = `STL_SAMPLE_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire stl_pkg::stl_bus_req_type bus_req,
  output logic [15:0] rdata,
  input wire logic pos_ext_limit_in_n,
  input wire logic neg_ext_limit_in_n,
  input wire logic [1:0] aux_func_in_n,
  input wire logic signed [15:0] analog_ref,
  input wire logic signed [15:0] torque_cmd,
  output logic signed [15:0] torque_out,
  output logic signed [15:0] torque_ffwd,
  output logic [8:0] eff_pos_limit,
  output logic [8:0] eff_neg_limit
);
  import stl_pkg::*;

  // ****************************************
  // reset release
  // ****************************************
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ****************************************
  // settings
  // ****************************************
  stl_pct_type internal_pos_torque_limit_q;
  stl_pct_type internal_neg_torque_limit_q;
  stl_pct_type external_pos_torque_limit_q;
  stl_pct_type external_neg_torque_limit_q;
  stl_pct_type motor_max_q;
  logic [1:0] speed_control_option_q;
  logic [7:0] torque_ref_input_gain_q;
  logic [1:0] control_mode_select_q;

  // values above the range saturate to 300
  function automatic stl_pct_type sat_pct(input logic [15:0] v);
    sat_pct = (v > {7'h0, `STL_LIMIT_MAX}) ? `STL_LIMIT_MAX : v[8:0];
  endfunction : sat_pct

  function automatic stl_pct_type min_pct(input stl_pct_type a, input stl_pct_type b);
    min_pct = (a < b) ? a : b;
  endfunction : min_pct

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      internal_pos_torque_limit_q <= `STL_INT_RESET;
      internal_neg_torque_limit_q <= `STL_INT_RESET;
      external_pos_torque_limit_q <= `STL_EXT_RESET;
      external_neg_torque_limit_q <= `STL_EXT_RESET;
      motor_max_q <= `STL_MOTOR_MAX_RESET;
      speed_control_option_q <= `STL_SPD_OPT_RESET;
      torque_ref_input_gain_q <= `STL_GAIN_RESET;
      control_mode_select_q <= `STL_MODE_RESET;
    end else if (bus_req.we) begin
      unique case (bus_req.addr)
        `STL_OFS_INT_POS: internal_pos_torque_limit_q <= sat_pct(bus_req.wdata);
        `STL_OFS_INT_NEG: internal_neg_torque_limit_q <= sat_pct(bus_req.wdata);
        `STL_OFS_EXT_POS: external_pos_torque_limit_q <= sat_pct(bus_req.wdata);
        `STL_OFS_EXT_NEG: external_neg_torque_limit_q <= sat_pct(bus_req.wdata);
        `STL_OFS_SPD_OPT: speed_control_option_q <= bus_req.wdata[1:0];
        `STL_OFS_GAIN: torque_ref_input_gain_q <= bus_req.wdata[7:0];
        `STL_OFS_MODE: control_mode_select_q <= bus_req.wdata[1:0];
        `STL_OFS_MOTOR_MAX: motor_max_q <= sat_pct(bus_req.wdata);
        default: ;
      endcase
    end
  end

  // ****************************************
  // limit inputs
  // ****************************************
  logic [1:0] terminal_n;
  logic [1:0] held_n;
  // a terminal reads active when any function mapped to it is active
  assign terminal_n = {neg_ext_limit_in_n & aux_func_in_n[1],
                       pos_ext_limit_in_n & aux_func_in_n[0]};

  stl_input_sampler #(
    .PERIOD(SAMPLE_CYC)
  ) u_sampler (
    .clk(clk),
    .rst_n(rst_n_q),
    .raw_n(terminal_n),
    .held_n(held_n)
  );

  // ****************************************
  // analog reference path
  // ****************************************
  logic [15:0] analog_mag;
  logic [23:0] analog_scaled;
  stl_pct_type analog_pct;
  logic alimit_sel;
  logic ffwd_sel;
  logic alimit_on;

  // magnitude only; sign of the reference is ignored
  assign analog_mag = analog_ref[15] ? 16'(-analog_ref) : analog_ref;
  // gain scaled in units of 1/16 percent per count
  assign analog_scaled = 24'(analog_mag) * 24'(torque_ref_input_gain_q);
  assign analog_pct = (analog_scaled[23:4] > {11'h0, `STL_LIMIT_MAX}) ? `STL_LIMIT_MAX
                      : analog_scaled[12:4];
  // option field picks at most one use of the terminal
  assign alimit_sel = (speed_control_option_q == `STL_OPT_ALIMIT);
  assign ffwd_sel = (speed_control_option_q == `STL_OPT_FFWD);
  assign alimit_on = alimit_sel && (control_mode_select_q != `STL_MODE_TORQUE);

  // ****************************************
  // effective limits
  // ****************************************
  stl_pct_type pos_d;
  stl_pct_type neg_d;
  always_comb begin
    pos_d = internal_pos_torque_limit_q;
    neg_d = internal_neg_torque_limit_q;
    if (!held_n[0]) begin
      pos_d = min_pct(pos_d, external_pos_torque_limit_q);
    end
    if (!held_n[1]) begin
      neg_d = min_pct(neg_d, external_neg_torque_limit_q);
    end
    if (alimit_on) begin
      pos_d = min_pct(pos_d, analog_pct);
      neg_d = min_pct(neg_d, analog_pct);
    end
    pos_d = min_pct(pos_d, motor_max_q);
    neg_d = min_pct(neg_d, motor_max_q);
  end

  // recomputed every cycle so writes act without a restart
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      eff_pos_limit <= 9'h0;
      eff_neg_limit <= 9'h0;
    end else begin
      eff_pos_limit <= pos_d;
      eff_neg_limit <= neg_d;
    end
  end

  // ****************************************
  // torque clamp
  // ****************************************
  // command is in percent of rated torque, one count per percent
  logic signed [15:0] pos_lim_s;
  logic signed [15:0] neg_lim_s;
  assign pos_lim_s = $signed({7'h0, eff_pos_limit});
  assign neg_lim_s = -$signed({7'h0, eff_neg_limit});

  // clamp uses the registered limits, adding one cycle of lag
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      torque_out <= 16'sh0;
      torque_ffwd <= 16'sh0;
    end else begin
      if (torque_cmd > pos_lim_s) begin
        torque_out <= pos_lim_s;
      end else if (torque_cmd < neg_lim_s) begin
        torque_out <= neg_lim_s;
      end else begin
        torque_out <= torque_cmd;
      end
      torque_ffwd <= ffwd_sel ? $signed(analog_scaled[19:4]) : 16'sh0;
    end
  end

  // ****************************************
  // register read port
  // ****************************************
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rdata <= 16'h0;
    end else if (bus_req.re) begin
      unique case (bus_req.addr)
        `STL_OFS_INT_POS: rdata <= {7'h0, internal_pos_torque_limit_q};
        `STL_OFS_INT_NEG: rdata <= {7'h0, internal_neg_torque_limit_q};
        `STL_OFS_EXT_POS: rdata <= {7'h0, external_pos_torque_limit_q};
        `STL_OFS_EXT_NEG: rdata <= {7'h0, external_neg_torque_limit_q};
        `STL_OFS_SPD_OPT: rdata <= {14'h0, speed_control_option_q};
        `STL_OFS_GAIN: rdata <= {8'h0, torque_ref_input_gain_q};
        `STL_OFS_MODE: rdata <= {14'h0, control_mode_select_q};
        `STL_OFS_MOTOR_MAX: rdata <= {7'h0, motor_max_q};
        `STL_OFS_STATUS: rdata <= {12'h0, ffwd_sel, alimit_on, ~held_n};
        `STL_OFS_EFF_POS: rdata <= {7'h0, eff_pos_limit};
        `STL_OFS_EFF_NEG: rdata <= {7'h0, eff_neg_limit};
        `STL_OFS_AUX_IN: rdata <= {14'h0, terminal_n};
        default: rdata <= 16'h0;
      endcase
    end else begin
      rdata <= 16'h0;
    end
  end
endmodule : stl_torque_limit
`default_nettype wire

/* File: verif/stl_host_model.sv */
// host controller model driving the low-active limit terminals
// assumes the bench sets the request levels right after a rising edge
`default_nettype none
module stl_host_model (
  input wire logic pos_on,
  input wire logic neg_on,
  input wire logic [1:0] aux_on,
  output logic pos_n,
  output logic neg_n,
  output logic [1:0] aux_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // terminals are levels, pulled high when idle
  assign pos_n = ~pos_on;
  assign neg_n = ~neg_on;
  assign aux_n = ~aux_on;
endmodule : stl_host_model
`default_nettype wire

/* File: verif/stl_torque_limit_assertions.sv */
// port checker for the torque limit selector
// assumes a bind from the bench top and a sample period of 4 cycles or less
`default_nettype none
module stl_torque_limit_assertions #(
  parameter int unsigned SAMPLE_CYC = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire stl_pkg::stl_bus_req_type bus_req,
  input wire logic [15:0] rdata,
  input wire logic pos_ext_limit_in_n,
  input wire logic neg_ext_limit_in_n,
  input wire logic [1:0] aux_func_in_n,
  input wire logic signed [15:0] analog_ref,
  input wire logic signed [15:0] torque_cmd,
  input wire logic signed [15:0] torque_out,
  input wire logic signed [15:0] torque_ffwd,
  input wire logic [8:0] eff_pos_limit,
  input wire logic [8:0] eff_neg_limit
);
  timeunit 1ns;
  timeprecision 1ps;
  import stl_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ****************
  // sequences
  // ****************
  // limits held long enough for the clamp stage to have caught up
  sequence s_lim_still;
    ($stable(eff_pos_limit) && $stable(eff_neg_limit))[*3];
  endsequence
  // nothing moving; a long sample period would leave a tick pending, hence the gate
  sequence s_quiet;
    (SAMPLE_CYC <= 4 && !bus_req.we && $stable(analog_ref) && $stable(torque_cmd)
      && $stable({pos_ext_limit_in_n, neg_ext_limit_in_n, aux_func_in_n}))[*8];
  endsequence
  a_pos_cap: assert property (eff_pos_limit <= 9'h12C) else $error("positive limit above ceiling");
  a_neg_cap: assert property (eff_neg_limit <= 9'h12C) else $error("negative limit above ceiling");
  a_clamp_pos: assert property (s_lim_still |-> $signed(torque_out) <= $signed({7'h00, eff_pos_limit}))
    else $error("torque above positive limit");
  a_clamp_neg: assert property (s_lim_still |-> $signed(torque_out) + $signed({7'h00, eff_neg_limit}) >= 0)
    else $error("torque below negative limit");
  a_eff_quiet: assert property (s_quiet |=> $stable(eff_pos_limit) && $stable(eff_neg_limit))
    else $error("limit moved with no cause");
  a_out_steady: assert property (s_quiet |=> $stable(torque_out)) else $error("torque moved with no cause");
  a_ffwd_zero: assert property ((analog_ref == 16'h0000)[*4] |-> torque_ffwd == 16'h0000)
    else $error("feed-forward without analog input");
  a_rdata_idle: assert property (!$past(bus_req.re) |-> rdata == 16'h0000) else $error("read data without read");
endmodule : stl_torque_limit_assertions
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench for the torque limit selector
// assumes hdl/ compiled first; sample period cut to 4 cycles
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import stl_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  stl_bus_req_type bus_req = '0;
  logic [15:0] rdata;
  logic pos_on = 1'b0;
  logic neg_on = 1'b0;
  logic [1:0] aux_on = 2'b00;
  logic pos_n;
  logic neg_n;
  logic [1:0] aux_n;
  logic signed [15:0] analog_ref = 16'h0000;
  logic signed [15:0] torque_cmd = 16'h0000;
  logic signed [15:0] torque_out;
  logic signed [15:0] torque_ffwd;
  logic [8:0] eff_pos_limit;
  logic [8:0] eff_neg_limit;
  logic [15:0] rst_val [8] = '{16'h012C, 16'h012C, 16'h0064, 16'h0064, 16'h0000, 16'h000A, 16'h0000, 16'h012C};
  int mismatches = 0;
  int checks = 0;
  always #5 clk = ~clk;
  stl_torque_limit #(.SAMPLE_CYC(4)) u_stl_torque_limit (.clk(clk), .rstn(rstn), .bus_req(bus_req),
    .rdata(rdata), .pos_ext_limit_in_n(pos_n), .neg_ext_limit_in_n(neg_n), .aux_func_in_n(aux_n),
    .analog_ref(analog_ref), .torque_cmd(torque_cmd), .torque_out(torque_out), .torque_ffwd(torque_ffwd),
    .eff_pos_limit(eff_pos_limit), .eff_neg_limit(eff_neg_limit));
  stl_host_model u_stl_host_model (.pos_on(pos_on), .neg_on(neg_on), .aux_on(aux_on), .pos_n(pos_n),
    .neg_n(neg_n), .aux_n(aux_n));
  // ****************
  // tasks
  // ****************
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    bus_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    bus_req.we <= 1'b0;
  endtask : wr
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    bus_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    bus_req.re <= 1'b0;
    @(negedge clk);
    chk("rdata", rdata, exp);
  endtask : rd
  // command is always beyond the limits, so the output sits on one of them
  task automatic lim(input logic [15:0] p, input logic [15:0] n, input logic [15:0] f);
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk("eff_pos", {7'h00, eff_pos_limit}, p);
    chk("eff_neg", {7'h00, eff_neg_limit}, n);
    chk("torque_out", torque_out, torque_cmd[15] ? 16'h0000 - n : p);
    chk("torque_ffwd", torque_ffwd, f);
    @(posedge clk);
  endtask : lim
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  // ****************
  // sequence
  // ****************
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 8; i++) rd(i[3:0], rst_val[i]);
    rd(4'hC, 16'h0000);
    torque_cmd <= 16'h01F4;
    lim(16'h012C, 16'h012C, 16'h0000);
    torque_cmd <= 16'hFE0C;
    pos_on <= 1'b1;
    lim(16'h0064, 16'h012C, 16'h0000);
    neg_on <= 1'b1;
    lim(16'h0064, 16'h0064, 16'h0000);
    wr(4'h0, 16'h0032);
    lim(16'h0032, 16'h0064, 16'h0000);
    pos_on <= 1'b0;
    neg_on <= 1'b0;
    aux_on <= 2'b10;
    lim(16'h0032, 16'h0064, 16'h0000);
    rd(4'h8, 16'h0002);
    rd(4'hB, 16'h0001);
    aux_on <= 2'b00;
    wr(4'h0, 16'h012C);
    wr(4'h2, 16'h0190);
    rd(4'h2, 16'h012C);
    wr(4'h7, 16'h0078);
    lim(16'h0078, 16'h0078, 16'h0000);
    wr(4'h7, 16'h012C);
    wr(4'h5, 16'h0010);
    wr(4'h4, 16'h0001);
    analog_ref <= 16'hFFB0;
    lim(16'h0050, 16'h0050, 16'h0000);
    rd(4'h8, 16'h0004);
    rd(4'h9, 16'h0050);
    rd(4'hA, 16'h0050);
    wr(4'h6, 16'h0002);
    lim(16'h012C, 16'h012C, 16'h0000);
    wr(4'h6, 16'h0001);
    lim(16'h0050, 16'h0050, 16'h0000);
    wr(4'h4, 16'h0002);
    lim(16'h012C, 16'h012C, 16'h0050);
    rd(4'h8, 16'h0008);
    wr(4'h5, 16'h0020);
    lim(16'h012C, 16'h012C, 16'h00A0);
    wr(4'h4, 16'h0000);
    lim(16'h012C, 16'h012C, 16'h0000);
    wr(4'h4, 16'h0003);
    lim(16'h012C, 16'h012C, 16'h0000);
    // a command inside both limits must pass through untouched
    torque_cmd <= 16'hFFE0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("torque_out", torque_out, 16'hFFE0);
    report_and_stop();
  end
  // hang guard, several times the expected run
  initial begin
    repeat (3000) @(posedge clk);
    mismatches++;
    report_and_stop();
  end
endmodule : tb_top
bind stl_torque_limit stl_torque_limit_assertions #(.SAMPLE_CYC(SAMPLE_CYC)) u_stl_torque_limit_assertions (
  .clk(clk), .rstn(rstn), .bus_req(bus_req), .rdata(rdata), .pos_ext_limit_in_n(pos_ext_limit_in_n),
  .neg_ext_limit_in_n(neg_ext_limit_in_n), .aux_func_in_n(aux_func_in_n), .analog_ref(analog_ref),
  .torque_cmd(torque_cmd), .torque_out(torque_out), .torque_ffwd(torque_ffwd),
  .eff_pos_limit(eff_pos_limit), .eff_neg_limit(eff_neg_limit));
`default_nettype wire
